/* File: bench/sde_estimator_checker.sv */
`timescale 1ns/1ps
`default_nettype none

// Port checker; every property is quiet while reset is held.
module sde_estimator_checker #(
   parameter longint UNIT_CYCLES = 4
) (
   input wire logic        CLOCK,
   input wire logic        RST_N,
   input wire logic [7:0]  REG_ADDR,
   input wire logic [7:0]  REG_WDATA,
   input wire logic        REG_WE,
   input wire logic        REG_RE,
   input wire logic [7:0]  REG_RDATA,
   input wire logic        CHARGING,
   input wire logic        CHG_COUNT,
   input wire logic        DSG_COUNT,
   input wire logic        VBAT_AT_TERM,
   input wire logic [3:0]  MAG_FILTER_THRESHOLD,
   input wire logic [7:0]  MAG_FILTER_UV,
   input wire logic [3:0]  SD_RATE_CODE,
   input wire logic [15:0] NOMINAL_AVAILABLE_CHARGE,
   input wire logic        SD_STEP,
   input wire logic        FULL_CHARGE
);
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RST_N);

   property p_cfg;
      logic [7:0] d;
      (REG_WE && REG_ADDR == 8'h7a, d = REG_WDATA) |-> ##2
         (MAG_FILTER_THRESHOLD == d[7:4] && SD_RATE_CODE == d[3:0]);
   endproperty
   a_cfg: assert property (p_cfg) else $error("config fields wrong");
   property p_uv;
      $stable(MAG_FILTER_THRESHOLD) |-> MAG_FILTER_UV == MAG_FILTER_THRESHOLD * 8'h06;
   endproperty
   a_uv: assert property (p_uv) else $error("filter microvolts wrong");
   property p_chg_step;
      SD_STEP |-> !$past(CHARGING);
   endproperty
   a_chg_step: assert property (p_chg_step) else $error("step while charging");
   property p_sub;
      SD_STEP && !$past(CHG_COUNT) && !$past(DSG_COUNT) |-> NOMINAL_AVAILABLE_CHARGE == $past(NOMINAL_AVAILABLE_CHARGE) - ($past(NOMINAL_AVAILABLE_CHARGE) >> 9);
   endproperty
   a_sub: assert property (p_sub) else $error("step amount wrong");
   // The shortest interval is one unit, four cycles in simulation.
   property p_pulse;
      SD_STEP |=> !SD_STEP [*3];
   endproperty
   a_pulse: assert property (p_pulse) else $error("steps too close");
   property p_up;
      CHG_COUNT && !DSG_COUNT && NOMINAL_AVAILABLE_CHARGE != 16'hffff |=> SD_STEP || NOMINAL_AVAILABLE_CHARGE == $past(NOMINAL_AVAILABLE_CHARGE) + 16'h0001;
   endproperty
   a_up: assert property (p_up) else $error("count up wrong");
   property p_dn;
      DSG_COUNT && !CHG_COUNT && NOMINAL_AVAILABLE_CHARGE != 16'h0000 |=> SD_STEP || NOMINAL_AVAILABLE_CHARGE == $past(NOMINAL_AVAILABLE_CHARGE) - 16'h0001;
   endproperty
   a_dn: assert property (p_dn) else $error("count down wrong");
   property p_full_clr;
      !CHARGING |=> !FULL_CHARGE;
   endproperty
   a_full_clr: assert property (p_full_clr) else $error("full kept");
   property p_full_set;
      $rose(FULL_CHARGE) |-> $past(CHARGING && VBAT_AT_TERM);
   endproperty
   a_full_set: assert property (p_full_set) else $error("full without cause");
   property p_taper;
      logic [7:0] d;
      (REG_WE && REG_ADDR == 8'h7b, d = REG_WDATA) ##2
         (REG_RE && !REG_WE && REG_ADDR == 8'h7b) |=> REG_RDATA == d;
   endproperty
   a_taper: assert property (p_taper) else $error("taper readback wrong");
   c_step: cover property (SD_STEP);
   c_full: cover property (FULL_CHARGE && CHARGING);
   c_taper: cover property (REG_WE && REG_ADDR == 8'h7b);
endmodule : sde_estimator_checker

bind sde_estimator sde_estimator_checker #(.UNIT_CYCLES(UNIT_CYCLES)) u_chk (
   .CLOCK(CLOCK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
   .REG_WE(REG_WE), .REG_RE(REG_RE), .REG_RDATA(REG_RDATA), .CHARGING(CHARGING),
   .CHG_COUNT(CHG_COUNT), .DSG_COUNT(DSG_COUNT), .VBAT_AT_TERM(VBAT_AT_TERM),
   .MAG_FILTER_THRESHOLD(MAG_FILTER_THRESHOLD), .MAG_FILTER_UV(MAG_FILTER_UV),
   .SD_RATE_CODE(SD_RATE_CODE), .NOMINAL_AVAILABLE_CHARGE(NOMINAL_AVAILABLE_CHARGE), .SD_STEP(SD_STEP), .FULL_CHARGE(FULL_CHARGE));

`default_nettype wire

/* File: bench/sde_estimator_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module sde_estimator_tb;
   // Row: config byte, temperature, expected microvolts, expected step gap.
   typedef struct {
      logic [7:0]        cfg;
      logic signed [7:0] t;
      logic [7:0]        uv;
      int                cyc;
   } sde_row_t;
   sde_row_t rows [11] = '{
      '{8'h01, 60, 8'h00, 4}, '{8'h11, 59, 8'h06, 8}, '{8'h21, 40, 8'h0c, 16},
      '{8'h31, 30, 8'h12, 32}, '{8'h41, 20, 8'h18, 64}, '{8'h51, 10, 8'h1e, 128},
      '{8'h61, 0, 8'h24, 256}, '{8'hf1, -20, 8'h5a, 256}, '{8'h8c, 25, 8'h30, 768},
      '{8'h9c, 35, 8'h36, 384}, '{8'h7c, 29, 8'h2a, 768}};
   logic clock, rst_n, charging, chg_count, dsg_count, vbat_at_term;
   logic signed [7:0] temp_c;
   logic [15:0] charge_current, nominal_available_charge, p;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, uv, d;
   logic reg_we, reg_re, sd_step, full;
   logic [3:0] thr, code;
   int mismatches, checks_done, steps, n;

   sde_host u_host (.clk(clock), .addr(reg_addr), .wdata(reg_wdata), .we(reg_we),
      .re(reg_re), .rdata(reg_rdata));
   // A four-cycle unit keeps the long intervals short.
   sde_estimator #(.UNIT_CYCLES(4)) DUT (.CLOCK(clock), .RST_N(rst_n),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WE(reg_we), .REG_RE(reg_re),
      .REG_RDATA(reg_rdata), .CHARGING(charging), .CHG_COUNT(chg_count),
      .DSG_COUNT(dsg_count), .TEMP_C(temp_c), .CHARGE_CURRENT(charge_current),
      .VBAT_AT_TERM(vbat_at_term), .MAG_FILTER_THRESHOLD(thr), .MAG_FILTER_UV(uv),
      .SD_RATE_CODE(code), .NOMINAL_AVAILABLE_CHARGE(nominal_available_charge), .SD_STEP(sd_step), .FULL_CHARGE(full));

   // Comparison with four-state equality so an unknown never matches.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Counts falling edges to the next step and checks the amount taken.
   task automatic gap(output int k);
      k = 0;
      do begin
         p = nominal_available_charge;
         @(negedge clock);
         k++;
      end while (sd_step !== 1'b1 && k < 4000);
      chk(nominal_available_charge, p - (p >> 9));
   endtask : gap

   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : stop_test

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // Steps are counted at falling edges, where the pulse is settled.
   always @(negedge clock) if (sd_step === 1'b1) steps++;

   // The whole run is under eight thousand cycles; this is five times that.
   initial begin
      #160000;
      mismatches++;
      stop_test();
   end

   initial begin
      {rst_n, charging, chg_count, dsg_count, vbat_at_term} = 5'h00;
      temp_c = 8'sh19;
      charge_current = 16'hffff;
      repeat (6) @(negedge clock);
      rst_n = 1'b1;
      // Charge the counter while charging parks the estimator in hold.
      charging = 1'b1;
      chg_count = 1'b1;
      repeat (2048) @(negedge clock);
      chg_count = 1'b0;
      @(negedge clock);
      chk(nominal_available_charge, 16'h0800);
      charging = 1'b0;
      foreach (rows[i]) begin
         temp_c = rows[i].t;
         u_host.wr(8'h7a, rows[i].cfg);
         @(negedge clock);
         chk(16'(thr), 16'(rows[i].cfg[7:4]));
         chk(16'(uv), 16'(rows[i].uv));
         chk(16'(code), 16'(rows[i].cfg[3:0]));
         gap(n);
         gap(n);
         chk(16'(n), 16'(rows[i].cyc));
      end
      $display("interval table done");
      // Full charge needs current strictly under taper times 32.
      u_host.wr(8'h7a, 8'h01);
      u_host.wr(8'h7b, 8'h02);
      u_host.rd(8'h7b, d);
      chk(16'(d), 16'h0002);
      {charging, vbat_at_term} = 2'b11;
      charge_current = 16'h0040;
      steps = 0;
      repeat (64) @(negedge clock);
      chk(16'(steps), 16'h0000);
      chk(16'(full), 16'h0000);
      charge_current = 16'h003f;
      repeat (2) @(negedge clock);
      chk(16'(full), 16'h0001);
      charging = 1'b0;
      repeat (2) @(negedge clock);
      chk(16'(full), 16'h0000);
      $display("charge test done");
      // Code zero stops steps; an unmapped write and read change nothing.
      u_host.wr(8'h7a, 8'h00);
      u_host.wr(8'h79, 8'hff);
      u_host.rd(8'h79, d);
      chk(16'(d), 16'h0000);
      p = nominal_available_charge;
      steps = 0;
      dsg_count = 1'b1;
      repeat (5) @(negedge clock);
      dsg_count = 1'b0;
      repeat (40) @(negedge clock);
      chk(nominal_available_charge, p - 16'h0005);
      chk(16'(steps), 16'h0000);
      $display("discharge test done");
      // A reset in mid-run clears the counter and restores the config byte.
      rst_n = 1'b0;
      repeat (6) @(negedge clock);
      chk(nominal_available_charge, 16'h0000);
      chk(16'(reg_rdata), 16'h0000);
      rst_n = 1'b1;
      u_host.rd(8'h7a, d);
      chk(16'(d), 16'(sde_pkg::FSD_CFG_RST));
      @(negedge clock);
      chk(16'(code), 16'h000c);
      $display("reset test done");
      stop_test();
   end
endmodule : sde_estimator_tb

`default_nettype wire

/* File: bench/sde_host.sv */
`timescale 1ns/1ps
`default_nettype none

// Host model: moves one byte per strobe and drives only at falling edges.
module sde_host (
   input  wire logic       clk,
   output var  logic [7:0] addr,
   output var  logic [7:0] wdata,
   output var  logic       we,
   output var  logic       re,
   input  wire logic [7:0] rdata
);
   // The bus stays idle until the first transfer.
   initial begin
      addr = 8'h00;
      wdata = 8'h00;
      we = 1'b0;
      re = 1'b0;
   end

   // Callers enter at a falling edge; each transfer ends with one idle
   // cycle, so a following call never raises a strobe just lowered.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      we = 1'b1;
      @(posedge clk);
      @(negedge clk);
      we = 1'b0;
      @(negedge clk);
   endtask : wr

   // Read data is registered, so it is taken after the strobe edge.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      addr = a;
      re = 1'b1;
      @(posedge clk);
      @(negedge clk);
      re = 1'b0;
      d = rdata;
      @(negedge clk);
   endtask : rd
endmodule : sde_host

`default_nettype wire

/* File: logic/sde_estimator.sv */
// Operation
// RULE1 - Filter threshold is config bits 7:4, 6uV
// RULE2 - Rate code is config bits 3:0
// RULE3 - No self-discharge steps while charging
// RULE4 - Each step subtracts charge counter over 512
// RULE5 - Rate unscaled from 20C up to 30C
// RULE6 - Double per hotter band, 16x cap
// RULE7 - Halve per colder band, quarter floor
// RULE8 - Code 12 at reference: one step daily
// RULE9 - Code 12 one band hotter: every 12h
// RULE10 - Taper threshold plus voltage flags full charge
// RULE11 - Taper byte counts 192uV of sense voltage
// RULE12 - Interval two hours per code, band scaled
// RULE13 - Charge counter up on charge, down discharge
`timescale 1ns/1ps
`default_nettype none

module sde_estimator #(
   // Clock cycles per interval unit; shorten for simulation.
   parameter longint UNIT_CYCLES = sde_pkg::SD_UNIT_CYCLES
) (
   input  wire logic              CLOCK,
   input  wire logic              RST_N,
   input  wire logic [7:0]        REG_ADDR,
   input  wire logic [7:0]        REG_WDATA,
   input  wire logic              REG_WE,
   input  wire logic              REG_RE,
   output var  logic [7:0]        REG_RDATA,
   input  wire logic              CHARGING,
   input  wire logic              CHG_COUNT,
   input  wire logic              DSG_COUNT,
   input  wire logic signed [7:0] TEMP_C,
   input  wire logic [15:0]       CHARGE_CURRENT,
   input  wire logic              VBAT_AT_TERM,
   output var  logic [3:0]        MAG_FILTER_THRESHOLD,
   output var  logic [7:0]        MAG_FILTER_UV,
   output var  logic [3:0]        SD_RATE_CODE,
   output var  logic [15:0]       NOMINAL_AVAILABLE_CHARGE,
   output var  logic              SD_STEP,
   output var  logic              FULL_CHARGE
);

   // Stored configuration bytes.
   logic [7:0]                    fsd_cfg_q;      // Filter and self-discharge byte.
   logic [7:0]                    taper_q;        // Taper current threshold byte.

   // Decoded fields of the configuration byte.
   logic [3:0]                    filt_thr;       // Filter threshold field.
   logic [3:0]                    rate_code;      // Self-discharge rate code field.

   // Interval timing.
   logic                          unit_tick;      // One pulse per interval unit.
   logic [2:0]                    band_shift;     // Units per code count, as a power of two.
   logic [sde_pkg::INTV_W-1:0]    interval;       // Units between two steps.
   logic [sde_pkg::INTV_W-1:0]    elapsed_q;      // Units counted toward the next step.
   logic [sde_pkg::INTV_W-1:0]    elapsed_d;      // Next unit count.
   logic                          step_fire;      // A step is taken this cycle.

   // Estimator state.
   sde_pkg::sde_state_t           state_q;        // Present state.
   sde_pkg::sde_state_t           state_d;        // Next state.

   // Charge counter arithmetic.
   logic [sde_pkg::NAC_W-1:0]     nac_q;          // Nominal available charge.
   logic [sde_pkg::NAC_W-1:0]     nac_d;          // Next charge value.
   logic [sde_pkg::NAC_W-1:0]     step_amt;       // Amount removed by one step.

   // Full-charge detection.
   logic [15:0]                   taper_cur;      // Taper threshold in current units.
   logic                          full_cond;      // Full-charge condition met now.

   // Unit time base, shared by every temperature band.
   // The forty-bit divider covers a full-length unit at this clock; a much
   // faster clock would need a wider count.
   sde_tick_gen #(
      .W      (sde_pkg::UNIT_W),
      .PERIOD (UNIT_CYCLES)
   ) u_unit (
      .clk   (CLOCK),
      .rst_n (RST_N),
      .tick  (unit_tick)
   );

   // Register writes. A write lands on the next edge; unmapped writes
   // are dropped without effect, so they cannot disturb the configuration.
   // A read of a byte in the cycle of its write still returns the old value.
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         fsd_cfg_q <= sde_pkg::FSD_CFG_RST;
         taper_q   <= sde_pkg::TAPER_RST;
      end else if (REG_WE) begin
         if (REG_ADDR == sde_pkg::ADDR_FSD_CFG) begin
            fsd_cfg_q <= REG_WDATA;
         end
         if (REG_ADDR == sde_pkg::ADDR_TAPER) begin
            taper_q <= REG_WDATA;
         end
      end
   end

   // Register reads. Data appears one cycle after the read strobe and
   // holds until the next strobe; unmapped addresses read as zero.
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         REG_RDATA <= sde_pkg::RDATA_UNMAPPED;
      end else if (REG_RE) begin
         case (REG_ADDR)
            sde_pkg::ADDR_FSD_CFG: begin
               REG_RDATA <= fsd_cfg_q;
            end
            sde_pkg::ADDR_TAPER: begin
               REG_RDATA <= taper_q;
            end
            default: begin
               REG_RDATA <= sde_pkg::RDATA_UNMAPPED;
            end
         endcase
      end
   end

   // Field decode of the configuration byte.
   // The fields are taken straight from the stored byte, with no check.
   assign filt_thr  = fsd_cfg_q[sde_pkg::FILT_MSB:sde_pkg::FILT_LSB]; // RULE1
   assign rate_code = fsd_cfg_q[sde_pkg::RATE_MSB:sde_pkg::RATE_LSB]; // RULE2

   // Decoded fields are published from flops; the filter threshold is
   // also given in microvolts so the filter needs no multiplier.
   // The one-cycle lag behind a write is harmless for a slow filter.
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         MAG_FILTER_THRESHOLD <= '0;
         MAG_FILTER_UV        <= '0;
         SD_RATE_CODE         <= '0;
      end else begin
         MAG_FILTER_THRESHOLD <= filt_thr;
         MAG_FILTER_UV        <= 8'(filt_thr * sde_pkg::FILT_UV_PER_CNT); // RULE1
         SD_RATE_CODE         <= rate_code;
      end
   end

   // Temperature band to interval shift. A hotter band halves the
   // interval, which doubles the rate; a colder band doubles it.
   // Below ten degrees every reading shares one band, because the rate
   // never falls under a quarter; readings are signed whole degrees.
   always_comb begin
      if (TEMP_C >= sde_pkg::T_60) begin
         band_shift = sde_pkg::SH_60;    // RULE6
      end else if (TEMP_C >= sde_pkg::T_50) begin
         band_shift = sde_pkg::SH_50;    // RULE6
      end else if (TEMP_C >= sde_pkg::T_40) begin
         band_shift = sde_pkg::SH_40;    // RULE6
      end else if (TEMP_C >= sde_pkg::T_30) begin
         band_shift = sde_pkg::SH_30;    // RULE9
      end else if (TEMP_C >= sde_pkg::T_20) begin
         band_shift = sde_pkg::SH_REF;   // RULE5
      end else if (TEMP_C >= sde_pkg::T_10) begin
         band_shift = sde_pkg::SH_10;    // RULE7
      end else begin
         band_shift = sde_pkg::SH_COLD;  // RULE7
      end
   end

   // Interval in units: the code times sixteen units (two hours) at the
   // reference band, so code 12 gives 192 units, twenty-four hours.
   // The longest interval, code 15 in the cold band, is 960 units, so
   // the ten-bit count never wraps.
   assign interval = sde_pkg::INTV_W'(rate_code) << band_shift; // RULE12 RULE8

   // Estimator state. Code zero turns the estimator off, since no
   // interval can express it; charging parks it in the hold state.
   always_comb begin
      case (state_q)
         sde_pkg::SD_OFF: begin
            if (rate_code == '0) begin
               state_d = sde_pkg::SD_OFF;
            end else if (CHARGING) begin
               state_d = sde_pkg::SD_HOLD;
            end else begin
               state_d = sde_pkg::SD_RUN;
            end
         end
         sde_pkg::SD_RUN: begin
            if (rate_code == '0) begin
               state_d = sde_pkg::SD_OFF;
            end else if (CHARGING) begin
               state_d = sde_pkg::SD_HOLD; // RULE3
            end else begin
               state_d = sde_pkg::SD_RUN;
            end
         end
         sde_pkg::SD_HOLD: begin
            if (rate_code == '0) begin
               state_d = sde_pkg::SD_OFF;
            end else if (CHARGING) begin
               state_d = sde_pkg::SD_HOLD;
            end else begin
               state_d = sde_pkg::SD_RUN;
            end
         end
         default: begin
            state_d = sde_pkg::SD_OFF;
         end
      endcase
   end

   // State register. An upset that leaves an illegal code falls back to
   // the off state through the default branch, losing only progress.
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         state_q <= sde_pkg::SD_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   // Step timing. Units only count in the run state, so time spent
   // charging is not credited; the elapsed count is kept, not cleared,
   // and the interval resumes where it stopped. Comparing with greater
   // or equal means a shorter interval after a warm-up fires at once.
   // A step may therefore come early once after a band change, never late.
   always_comb begin
      step_fire = 1'b0;
      elapsed_d = elapsed_q;
      if (state_q != sde_pkg::SD_RUN || CHARGING) begin
         step_fire = 1'b0;                 // RULE3
      end else if (unit_tick) begin
         if (elapsed_q + sde_pkg::INTV_W'(1) >= interval) begin
            step_fire = 1'b1;              // RULE12
            elapsed_d = '0;
         end else begin
            elapsed_d = elapsed_q + sde_pkg::INTV_W'(1);
         end
      end
      if (state_q == sde_pkg::SD_OFF) begin
         elapsed_d = '0;
      end
   end

   // Elapsed unit counter.
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         elapsed_q <= '0;
      end else begin
         elapsed_q <= elapsed_d;
      end
   end

   // One step takes a 1/512 share of the present charge value.
   assign step_amt = nac_q >> sde_pkg::NAC_STEP_SHIFT; // RULE4

   // Charge counter next value. The step is applied first, then the
   // count pulse; opposing pulses in one cycle cancel. The counter
   // saturates at both ends so a stray pulse cannot wrap it.
   // Below 512 counts a step removes nothing, so a nearly empty counter
   // is no longer aged; that is the price of a shift instead of a divide.
   always_comb begin
      nac_d = nac_q;
      if (step_fire) begin
         nac_d = nac_q - step_amt; // RULE4
      end
      if (CHG_COUNT && !DSG_COUNT && nac_d != '1) begin
         nac_d = nac_d + sde_pkg::NAC_W'(1); // RULE13
      end else if (DSG_COUNT && !CHG_COUNT && nac_d != '0) begin
         nac_d = nac_d - sde_pkg::NAC_W'(1); // RULE13
      end
   end

   // Charge counter and the step strobe.
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         nac_q   <= '0;
         SD_STEP <= 1'b0;
      end else begin
         nac_q   <= nac_d;
         SD_STEP <= step_fire;
      end
   end

   // The published counter comes from the flop itself.
   assign NOMINAL_AVAILABLE_CHARGE = nac_q;

   // Taper threshold in 6 uV current counts: 192 uV per taper count.
   // The shift is exact because the two scales differ by a power of two.
   assign taper_cur = 16'(taper_q) << sde_pkg::TAPER_SHIFT; // RULE11

   // Full charge needs the cell at its termination voltage while the
   // charge current has tapered below the threshold.
   assign full_cond = CHARGING && VBAT_AT_TERM && (CHARGE_CURRENT < taper_cur); // RULE10

   // Full flag. It holds once set and drops when charging stops; a
   // detection in the same cycle as the drop keeps the flag set.
   // Detection needs charging, so in practice the two never collide.
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         FULL_CHARGE <= 1'b0;
      end else if (full_cond) begin
         FULL_CHARGE <= 1'b1; // RULE10
      end else if (!CHARGING) begin
         FULL_CHARGE <= 1'b0;
      end
   end

endmodule : sde_estimator

`default_nettype wire

/* File: logic/sde_estimator_fix.sv */
`timescale 1ns/1ps
`default_nettype none

`default_nettype wire

/* File: logic/sde_pkg.sv */
`default_nettype none

// Shared constants for the self-discharge estimator.
package sde_pkg;

   // Register map of the configuration byte pair.
   localparam logic [7:0] ADDR_FSD_CFG    = 8'h7a;
   localparam logic [7:0] ADDR_TAPER      = 8'h7b;

   // Reset values; the bytes would normally be loaded from nonvolatile storage.
   localparam logic [7:0] FSD_CFG_RST     = 8'h0c;
   localparam logic [7:0] TAPER_RST       = 8'h00;
   localparam logic [7:0] RDATA_UNMAPPED  = 8'h00;

   // Field positions inside the filter and self-discharge byte.
   localparam int         FILT_MSB        = 7;
   localparam int         FILT_LSB        = 4;
   localparam int         RATE_MSB        = 3;
   localparam int         RATE_LSB        = 0;

   // Scale factors in microvolts per count.
   localparam logic [7:0] FILT_UV_PER_CNT = 8'h06;
   localparam int         TAPER_UV_PER_CNT = 192;
   localparam int         CUR_UV_PER_CNT  = 6;
   // Taper counts convert to current counts by a power-of-two factor.
   localparam int         TAPER_SHIFT     = $clog2(TAPER_UV_PER_CNT / CUR_UV_PER_CNT);

   // Each self-discharge step removes one part in two to this power.
   localparam int         NAC_STEP_SHIFT  = 9;

   // Widths.
   localparam int         NAC_W           = 16;
   localparam int         INTV_W          = 10;
   localparam int         UNIT_W          = 40;

   // Interval time base: one unit is the reference interval of a code
   // count divided by the largest temperature factor.
   localparam longint     CODE_STEP_S     = 7200;
   localparam longint     MAX_FACTOR      = 16;
   localparam longint     SD_UNIT_S       = CODE_STEP_S / MAX_FACTOR;
   localparam longint     CLK_PERIOD_PS   = 4000;
   localparam longint     PS_PER_S        = 64'd1000000000000;
   localparam longint     SD_UNIT_CYCLES  = SD_UNIT_S * PS_PER_S / CLK_PERIOD_PS;

   // Temperature band edges in whole degrees Celsius.
   localparam logic signed [7:0] T_10     = 8'sh0a;
   localparam logic signed [7:0] T_20     = 8'sh14;
   localparam logic signed [7:0] T_30     = 8'sh1e;
   localparam logic signed [7:0] T_40     = 8'sh28;
   localparam logic signed [7:0] T_50     = 8'sh32;
   localparam logic signed [7:0] T_60     = 8'sh3c;

   // Interval shift per band: units per code count are two to this power.
   localparam logic [2:0] SH_60           = 3'h0;
   localparam logic [2:0] SH_50           = 3'h1;
   localparam logic [2:0] SH_40           = 3'h2;
   localparam logic [2:0] SH_30           = 3'h3;
   localparam logic [2:0] SH_REF          = 3'h4;
   localparam logic [2:0] SH_10           = 3'h5;
   localparam logic [2:0] SH_COLD         = 3'h6;

   // Estimator states, one-hot.
   typedef enum logic [2:0] {
      SD_OFF  = 3'b001,
      SD_RUN  = 3'b010,
      SD_HOLD = 3'b100
   } sde_state_t;

endpackage : sde_pkg

`default_nettype wire

/* File: logic/sde_tick_gen.sv */
`timescale 1ns/1ps
`default_nettype none

// Free-running divider that pulses once every PERIOD clock cycles.
module sde_tick_gen #(
   parameter int     W      = 40,
   parameter longint PERIOD = 1000
) (
   input  wire logic clk,
   input  wire logic rst_n,
   output var  logic tick
);

   // Terminal count, cut to the counter width on purpose.
   localparam logic [W-1:0] LAST = W'(PERIOD - 1);

   logic [W-1:0] cnt_q;    // Cycles elapsed in the current unit.
   logic [W-1:0] cnt_d;    // Next count.
   logic         tick_d;   // Next tick.

   // The divider wraps at the terminal count and flags the wrap.
   always_comb begin
      if (cnt_q >= LAST) begin
         cnt_d  = '0;
         tick_d = 1'b1;
      end else begin
         cnt_d  = cnt_q + W'(1);
         tick_d = 1'b0;
      end
   end

   // Counter and registered tick.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick  <= tick_d;
      end
   end

endmodule : sde_tick_gen

`default_nettype wire
